// File: common/fault_resp_pkg.sv
// Package with field layout, encodings, timing constants and carrier types for fault response.
package fault_resp_pkg;

  // ---------------------------------------------------------------------------
  // Response byte layout
  // ---------------------------------------------------------------------------
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;

  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DELAYED = 2'h1;
  localparam logic [1:0] RESP_RETRY = 2'h2;
  localparam logic [1:0] RESP_HOLD = 2'h3;

  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  localparam logic [7:0] RESP_RESET = 8'h80;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int UNIT_WIDTH = 24;

  // Response byte split into its fields.
  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] delay;
  } resp_cfg_t;

  // Events that clear a latched fault.
  typedef struct packed {
    logic clear_faults;
    logic clear_bit;
    logic reset_pin;
  } clear_req_t;

endpackage : fault_resp_pkg

// File: hw/delay_timer.sv
// Delay timer that counts 2**code time units of a programmed length in clock cycles.
`timescale 1ns/100ps
module delay_timer #(
  parameter int UNIT_W = fault_resp_pkg::UNIT_WIDTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic start,
  input wire logic [2:0] code,
  input wire logic [UNIT_W-1:0] unit_cycles,
  output logic done
);
  import fault_resp_pkg::*;

  logic [UNIT_W-1:0] sub_q, sub_d;
  logic [7:0] units_q, units_d;
  logic run_q, run_d;

  // ---------------------------------------------------------------------------
  // Counting
  // ---------------------------------------------------------------------------
  // Start loads 2**code units; each unit lasts unit_cycles clocks (at least one).
  // Done looks only at the count, so a start issued in answer to it closes no loop.
  always_comb begin
    sub_d = sub_q;
    units_d = units_q;
    run_d = run_q;
    done = 1'b0;
    if (run_q) begin
      if (sub_q + UNIT_W'(1) >= unit_cycles) begin
        sub_d = '0;
        if (units_q == 8'h1) begin
          run_d = 1'b0;
          done = 1'b1;
        end else begin
          units_d = units_q - 8'h1;
        end
      end else begin
        sub_d = sub_q + UNIT_W'(1);
      end
    end
    if (start) begin
      run_d = 1'b1;
      sub_d = '0;
      units_d = 8'(8'h1 << code);
    end
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (srst) begin
      sub_q <= '0;
      units_q <= '0;
      run_q <= 1'b0;
    end else begin
      sub_q <= sub_d;
      units_q <= units_d;
      run_q <= run_d;
    end
  end

endmodule : delay_timer

// File: hw/fault_response.sv
// Fault response and restart sequencer for one monitored converter fault.
//
// What this block does
// [R1] Response 10: switch output off on fault, then follow retry field.
// [R2] Response 11: output stays off until the fault is cleared, incl. bit clear.
// [R3] Clear-faults command clears a latched fault and releases the output.
// [R4] Reset pin clears a latched fault.
// [R5] Commanding the output off then on clears a latched fault.
// [R6] Retry field sets restart count; 000 means no restart, stay off.
// [R7] Retry field 111 restarts without limit.
// [R8] Retry field 001 gives one restart; failure latches output off.
// [R9] Retry field 010 gives two restarts; failure latches output off.
// [R10] Restart start spacing equals delay count times the unit, plus one clock, for this fault.
// [R11] Response 00 ignores the fault entirely.
// [R12] Response 01 runs for the delay, then applies retry behaviour if fault remains.
// [R13] Retry values 011 to 110 give three to six restarts, then latch off.
// [R14] Delay code 0 to 7 means 1 to 128 units, unit set separately.
// [R15] Fault seen before regulation fails the attempt; count resets on clear.
`timescale 1ns/100ps
module fault_response #(
  parameter int UNIT_W = fault_resp_pkg::UNIT_WIDTH
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] resp_byte,
  input wire logic [UNIT_W-1:0] unit_cycles,
  input wire logic fault,
  input wire logic pgood,
  input wire logic output_on_cmd,
  input wire fault_resp_pkg::clear_req_t clear_req,
  output logic output_enable,
  output logic fault_latched,
  output logic [2:0] attempts
);
  import fault_resp_pkg::*;

  typedef enum logic [2:0] {
    ST_RUN, ST_GRACE, ST_WAIT, ST_RESTART, ST_HOLD, ST_LATCH
  } state_t;

  // ---------------------------------------------------------------------------
  // Field decode
  // ---------------------------------------------------------------------------
  function automatic resp_cfg_t split_cfg(input logic [7:0] b);
    resp_cfg_t c;
    c.resp = b[RESP_HI:RESP_LO];
    c.retry = b[RETRY_HI:RETRY_LO];
    c.delay = b[DELAY_HI:DELAY_LO];
    return c;
  endfunction : split_cfg

  // True while the retry budget still allows another restart.
  function automatic logic may_retry(input logic [2:0] lim, input logic [2:0] done_n);
    return (lim == RETRY_FOREVER) || (done_n < lim);
  endfunction : may_retry

  // True in the states that keep the output off until a clear arrives.
  function automatic logic held_state(input state_t s);
    return (s == ST_HOLD) || (s == ST_LATCH);
  endfunction : held_state

  resp_cfg_t cfg;
  state_t st_q, st_d;
  logic [2:0] cnt_q, cnt_d;
  logic on_q;
  logic clear_any;
  logic tmr_start, tmr_done;
  logic en_q, en_d;
  logic lat_q, lat_d;

  assign cfg = split_cfg(resp_byte);

  // ---------------------------------------------------------------------------
  // Clear sources
  // ---------------------------------------------------------------------------
  // Any clear source, or the off-to-on edge of the output command.
  assign clear_any = clear_req.clear_faults | clear_req.clear_bit | clear_req.reset_pin |
                     (output_on_cmd & ~on_q); // R3 R4 R5

  delay_timer #(.UNIT_W(UNIT_W)) u_timer (
    .clk(clk),
    .srst(srst),
    .start(tmr_start),
    .code(cfg.delay),
    .unit_cycles(unit_cycles),
    .done(tmr_done)
  ); // R14

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  // Next state, attempt count and output enable.
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    tmr_start = 1'b0;
    case (st_q)
      ST_RUN: begin
        if (fault) begin
          case (cfg.resp)
            RESP_IGNORE: st_d = ST_RUN; // R11
            RESP_DELAYED: begin
              st_d = ST_GRACE; // R12
              tmr_start = 1'b1;
            end
            RESP_RETRY: begin
              if (may_retry(cfg.retry, cnt_q)) begin // R1 R6
                st_d = ST_WAIT;
                tmr_start = 1'b1;
              end else begin
                st_d = ST_LATCH;
              end
            end
            default: st_d = ST_HOLD; // R2
          endcase
        end else if (pgood) begin
          cnt_d = '0;
        end
      end
      ST_GRACE: begin
        if (tmr_done) begin
          if (!fault) begin
            st_d = ST_RUN;
          end else if (may_retry(cfg.retry, cnt_q)) begin // R12
            st_d = ST_WAIT;
            tmr_start = 1'b1;
          end else begin
            st_d = ST_LATCH;
          end
        end
      end
      ST_WAIT: begin
        if (tmr_done) begin
          st_d = ST_RESTART; // R10
          cnt_d = cnt_q + 3'h1;
          tmr_start = 1'b1;
        end
      end
      ST_RESTART: begin
        if (fault) begin
          // Attempt failed before regulation was reached.
          if (may_retry(cfg.retry, cnt_q)) begin // R7 R8 R9 R13 R15
            st_d = ST_WAIT;
            tmr_start = 1'b1;
          end else begin
            st_d = ST_LATCH;
          end
        end else if (pgood) begin
          st_d = ST_RUN;
        end
      end
      ST_HOLD: begin
        if (!fault) begin
          st_d = ST_LATCH;
        end
      end
      ST_LATCH: st_d = ST_LATCH;
      default: st_d = ST_RUN;
    endcase
    if (clear_any && held_state(st_q)) begin
      st_d = ST_RUN; // R2 R3 R4 R5
      cnt_d = '0; // R15
    end
    en_d = output_on_cmd && (st_d == ST_RUN || st_d == ST_GRACE || st_d == ST_RESTART);
    lat_d = held_state(st_d); // R2 R6
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (srst) begin
      st_q <= ST_RUN;
      cnt_q <= '0;
      on_q <= 1'b0;
      en_q <= 1'b0;
      lat_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      on_q <= output_on_cmd;
      en_q <= en_d;
      lat_q <= lat_d;
    end
  end

  assign output_enable = en_q;
  assign fault_latched = lat_q;
  assign attempts = cnt_q;

  // ---------------------------------------------------------------------------
  // Check helpers
  // ---------------------------------------------------------------------------
  localparam int SPAN_W = UNIT_W + 8; // Eight more bits hold up to 128 units.

  // Clocks that one timed interval should last for a delay code and a unit length.
  function automatic logic [SPAN_W-1:0] span_of(input logic [2:0] code,
                                                input logic [UNIT_W-1:0] unit);
    logic [SPAN_W-1:0] len;
    len = (unit == '0) ? SPAN_W'(1) : SPAN_W'(unit);
    return len << code;
  endfunction : span_of

  logic [SPAN_W-1:0] gap_q, gap_d, span_q, span_d;
  logic [UNIT_W-1:0] unit_q, unit_d;

  // Counts clocks since the last timer start and keeps the span that start asked for.
  always_comb begin
    gap_d = gap_q + SPAN_W'(1);
    span_d = span_q;
    unit_d = unit_q;
    if (tmr_start) begin
      gap_d = '0;
      span_d = span_of(cfg.delay, unit_cycles);
      unit_d = unit_cycles;
    end
  end

  // Registers only.
  always_ff @(posedge clk) begin
    if (srst) begin
      gap_q <= '0;
      span_q <= SPAN_W'(1);
      unit_q <= '0;
    end else begin
      gap_q <= gap_d;
      span_q <= span_d;
      unit_q <= unit_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // A fault seen while the output runs under command.
  sequence s_fault_in_run;
    (st_q == ST_RUN) && fault && output_on_cmd;
  endsequence

  // A restart attempt that meets the fault again before regulation.
  sequence s_attempt_fails;
    (st_q == ST_RESTART) && fault;
  endsequence

  // Responses to a fault seen while running.
  a_ignore_keeps_on: assert property (@(posedge clk) disable iff (srst) // R11
    s_fault_in_run and (cfg.resp == RESP_IGNORE && !clear_req.reset_pin) |=> output_enable)
    else $error("output dropped under ignore response");
  a_retry_shuts_off: assert property (@(posedge clk) disable iff (srst) // R1
    s_fault_in_run and (cfg.resp == RESP_RETRY) |=> !output_enable)
    else $error("output not disabled on retry response");
  a_hold_shuts_off: assert property (@(posedge clk) disable iff (srst) // R2
    s_fault_in_run and (cfg.resp == RESP_HOLD) |=> !output_enable ##0 fault_latched)
    else $error("output not held off");
  a_zero_no_restart: assert property (@(posedge clk) disable iff (srst) // R6
    s_fault_in_run and (cfg.resp == RESP_RETRY && cfg.retry == RETRY_NONE && cnt_q == 3'h0)
    |=> st_q == ST_LATCH)
    else $error("restart attempted with zero retries");
  a_grace_keeps_on: assert property (@(posedge clk) disable iff (srst) // R12
    st_q == ST_GRACE && !tmr_done && output_on_cmd |=> output_enable)
    else $error("output dropped during grace delay");
  a_grace_expiry: assert property (@(posedge clk) disable iff (srst) // R12
    st_q == ST_GRACE && tmr_done && fault |=> (st_q == ST_WAIT) || (st_q == ST_LATCH))
    else $error("persistent fault not handled after grace delay");
  a_hold_latches: assert property (@(posedge clk) disable iff (srst) // R2
    st_q == ST_HOLD && !fault && !clear_any |=> st_q == ST_LATCH && !output_enable)
    else $error("hold released without clear");

  // Retry budget and restart timing.
  a_latch_stays_off: assert property (@(posedge clk) disable iff (srst) // R8 R9 R13
    st_q == ST_LATCH && !clear_any |=> st_q == ST_LATCH && !output_enable)
    else $error("latched fault released without clear");
  a_budget_latches: assert property (@(posedge clk) disable iff (srst) // R8 R9 R13
    s_attempt_fails and (cfg.retry != RETRY_FOREVER && cnt_q >= cfg.retry) |=> st_q == ST_LATCH)
    else $error("failed attempt beyond budget did not latch");
  a_endless_retries: assert property (@(posedge clk) disable iff (srst) // R7
    s_attempt_fails and (cfg.retry == RETRY_FOREVER) |=> st_q == ST_WAIT)
    else $error("endless retry stopped retrying");
  a_attempt_bound: assert property (@(posedge clk) disable iff (srst) // R7 R13
    cfg.retry != RETRY_FOREVER && $stable(cfg.retry) && st_q == ST_RESTART
    |-> cnt_q <= cfg.retry)
    else $error("attempt count exceeded retry limit");
  a_restart_after_wait: assert property (@(posedge clk) disable iff (srst) // R10
    st_q == ST_WAIT && tmr_done && !clear_any |=> st_q == ST_RESTART)
    else $error("restart did not follow delay");
  a_restart_enables: assert property (@(posedge clk) disable iff (srst) // R1 R10
    st_q == ST_WAIT && tmr_done && output_on_cmd |=> output_enable)
    else $error("restart did not enable the output");
  a_delay_span: assert property (@(posedge clk) disable iff (srst) // R10 R14
    tmr_done && unit_cycles == unit_q |-> gap_q == span_q - SPAN_W'(1))
    else $error("timed interval length wrong for delay code");
  a_count_resets: assert property (@(posedge clk) disable iff (srst) // R15
    st_q == ST_RUN && pgood && !fault |=> attempts == 3'h0)
    else $error("attempt count kept after regulation");

  // Clearing a latched fault.
  a_clear_releases: assert property (@(posedge clk) disable iff (srst) // R3
    fault_latched && clear_req.clear_faults |=> st_q == ST_RUN && cnt_q == 3'h0)
    else $error("clear did not release latch");
  a_reset_releases: assert property (@(posedge clk) disable iff (srst) // R4
    fault_latched && clear_req.reset_pin |=> !fault_latched)
    else $error("reset pin did not clear latch");
  a_cycle_releases: assert property (@(posedge clk) disable iff (srst) // R5
    fault_latched && output_on_cmd && !on_q |=> !fault_latched)
    else $error("on-off cycle did not clear latch");
  a_cmd_off_disables: assert property (@(posedge clk) disable iff (srst) // R5
    !output_on_cmd |=> !output_enable)
    else $error("output stayed on while commanded off");

endmodule : fault_response

// File: test/host_model.sv
// Host model that issues fault clears and output on and off commands.
`timescale 1ns/100ps
module host_model (
  input wire logic clk,
  output logic output_on_cmd,
  output fault_resp_pkg::clear_req_t clear_req
);
  import fault_resp_pkg::*;

  // The host starts with the output commanded on and no clear pending.
  initial begin
    output_on_cmd = 1'b1;
    clear_req = '0;
  end

  // Issues one clear: kinds 0 to 2 pulse one source, kind 3 cycles the output off and on.
  task automatic pulse_clear(input logic [1:0] kind);
    @(negedge clk);
    if (kind == 2'h3) begin
      output_on_cmd = 1'b0;
      repeat (4) @(negedge clk);
      output_on_cmd = 1'b1;
    end else begin
      clear_req = clear_req_t'(3'h4 >> kind);
      @(negedge clk);
      clear_req = '0;
    end
  endtask : pulse_clear
endmodule : host_model

// File: test/testbench.sv
// Self-checking testbench for the fault response sequencer.
`timescale 1ns/100ps
module testbench;
  import fault_resp_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] resp_byte = 8'h00;
  logic [23:0] unit_cycles = 24'h1;
  logic fault = 1'b0;
  logic pgood = 1'b0;
  logic output_on_cmd, output_enable, fault_latched, prev_en;
  clear_req_t clear_req;
  logic [2:0] attempts;
  int failures = 0, checks_done = 0, cyc = 0, rises = 0, last_rise = 0, gap = 0, base;

  fault_response #(.UNIT_W(24)) fault_response_inst (
    .clk(clk), .srst(srst), .resp_byte(resp_byte), .unit_cycles(unit_cycles),
    .fault(fault), .pgood(pgood), .output_on_cmd(output_on_cmd), .clear_req(clear_req),
    .output_enable(output_enable), .fault_latched(fault_latched), .attempts(attempts));
  host_model host_model_inst (.clk(clk), .output_on_cmd(output_on_cmd), .clear_req(clear_req));

  always #5 clk = ~clk;

  // The converter reaches regulation one cycle after enable while no fault is present.
  always @(negedge clk) pgood <= output_enable & ~fault;

  // Counts output restarts, keeps the last spacing and cuts a hang short.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    prev_en <= output_enable;
    if (output_enable === 1'b1 && prev_en === 1'b0) begin
      rises <= rises + 1;
      gap <= cyc - last_rise;
      last_rise <= cyc;
    end
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Expected length in clocks of a timed interval for a delay code and unit length.
  function automatic int exp_span(input logic [2:0] code, input int unit);
    return (1 << code) * unit;
  endfunction : exp_span

  // Holds a fault under disable and retry, then checks restarts, spacing and clearing.
  task automatic run_retry(input logic [2:0] n);
    int e;
    logic [2:0] d;
    d = 3'($urandom % 3);
    unit_cycles = 24'(1 + $urandom % 3);
    e = exp_span(d, int'(unit_cycles));
    resp_byte = {RESP_RETRY, n, d};
    base = rises;
    fault = 1'b1;
    for (int i = 0; i < 9 * (e + 9) && fault_latched !== 1'b1; i++) @(negedge clk);
    repeat (3) @(negedge clk);
    chk("restarts", 8'(n), 8'(rises - base));
    chk("attempts", {5'h0, n}, {5'h0, attempts});
    if (n > 3'h1) chk("gap", 8'h1, {7'h0, gap >= e - 2 && gap <= e + 2});
    fault = 1'b0;
    repeat (20) @(negedge clk);
    chk("held off", 8'h0, {7'h0, output_enable});
    host_model_inst.pulse_clear(2'(n));
    for (int i = 0; i < 20 && output_enable !== 1'b1; i++) @(negedge clk);
    repeat (4) @(negedge clk);
    chk("cleared", 8'h10, {3'h0, output_enable, 1'b0, attempts});
    $display("end of retry test %0d", n);
  endtask : run_retry

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude

  // Main sequence: reset, every retry count, endless retry, ignore, hold and delayed modes.
  initial begin
    void'($urandom(47));
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    for (int n = 0; n < 7; n++) run_retry(3'(n));
    resp_byte = {RESP_RETRY, RETRY_FOREVER, 3'h0};
    base = rises;
    fault = 1'b1;
    repeat (300) @(negedge clk);
    chk("endless", 8'h1, {7'h0, rises - base > 9 && fault_latched !== 1'b1});
    fault = 1'b0;
    repeat (30) @(negedge clk);
    chk("recovered", 8'h10, {3'h0, output_enable, 1'b0, attempts});
    $display("end of endless test");
    resp_byte = {RESP_IGNORE, 3'h1, 3'h0};
    base = rises;
    fault = 1'b1;
    repeat (40) @(negedge clk);
    fault = 1'b0;
    chk("ignored", 8'h1, {7'h0, rises == base && output_enable === 1'b1});
    $display("end of ignore test");
    resp_byte = {RESP_HOLD, 3'h2, 3'h0};
    fault = 1'b1;
    repeat (5) @(negedge clk);
    chk("hold off", 8'h0, {7'h0, output_enable});
    fault = 1'b0;
    repeat (20) @(negedge clk);
    chk("hold latched", 8'h1, {7'h0, fault_latched});
    host_model_inst.pulse_clear(2'h1);
    repeat (5) @(negedge clk);
    chk("hold cleared", 8'h1, {7'h0, output_enable});
    $display("end of hold test");
    resp_byte = {RESP_DELAYED, RETRY_NONE, 3'h2};
    unit_cycles = 24'h2;
    fault = 1'b1;
    repeat (2) @(negedge clk);
    fault = 1'b0;
    repeat (20) @(negedge clk);
    chk("short fault", 8'h1, {7'h0, output_enable});
    fault = 1'b1;
    repeat (5) @(negedge clk);
    chk("delay running", 8'h1, {7'h0, output_enable});
    repeat (8) @(negedge clk);
    chk("delay expired", 8'h1, {6'h0, output_enable, fault_latched});
    fault = 1'b0;
    host_model_inst.pulse_clear(2'h0);
    repeat (5) @(negedge clk);
    chk("delay cleared", 8'h1, {7'h0, output_enable});
    $display("end of delayed test");
    conclude();
  end
endmodule : testbench
